// ### shared/ufc_map.vh
// Register map, field positions and constants for the UART FIFO control block
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UFC_ADR_CTRL      4'h0
`define UFC_ADR_TXDATA    4'h1
`define UFC_ADR_RXDATA    4'h2
`define UFC_ADR_LEVELS    4'h3
`define UFC_ADR_IRQ_STAT  4'h4
`define UFC_ADR_IRQ_EN    4'h5
`define UFC_ADR_IRQ_CLR   4'h6
`define UFC_ADR_W         4

// ----------------------------------------------------------------
// fifo_control fields
// ----------------------------------------------------------------
`define UFC_CTL_EN        0
`define UFC_CTL_RXFL      1
`define UFC_CTL_TXFL      2
`define UFC_CTL_DMA       3
`define UFC_CTL_THR_LO    6
`define UFC_CTL_THR_HI    7
`define UFC_CTL_RESET     8'h00

// ----------------------------------------------------------------
// Thresholds and interrupt bits
// ----------------------------------------------------------------
`define UFC_THR_0         5'h01
`define UFC_THR_1         5'h04
`define UFC_THR_2         5'h08
`define UFC_THR_3         5'h0e
`define UFC_IRQ_TRIG      0
`define UFC_IRQ_TOUT      1
`define UFC_IRQ_RXOVR     2
`define UFC_IRQ_W         3

`endif

// ### test/ufc_line_model.sv
// Shift engine side model: feeds and takes characters
module ufc_line_model (
	// Clock
	input  wire logic       clk_i,
	// Strobes toward the block
	output logic            tx_take_o,
	output logic            rx_put_o,
	output logic [7:0]      rx_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		tx_take_o = 1'b0;
		rx_put_o = 1'b0;
		rx_data_o = 8'h00;
	end
	// Data line shows the inverse once released, never the stale byte
	task put(input logic [7:0] d);
		rx_put_o <= 1'b1;
		rx_data_o <= d;
		@(posedge clk_i);
		rx_put_o <= 1'b0;
		rx_data_o <= ~d;
		@(posedge clk_i);
	endtask
	task take;
		tx_take_o <= 1'b1;
		@(posedge clk_i);
		tx_take_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule // ufc_line_model

// ### test/ufc_top_props.sv
// Port checker for the FIFO control block
module ufc_top_props (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus and pins
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [3:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic        rx_put_i,
	input wire logic        tx_avail_o,
	input wire logic        tx_space_request_n_o,
	input wire logic        rx_data_request_n_o,
	input wire logic        fifo_enabled_o,
	input wire logic        rx_trigger_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----
	// Bus handshake and pins
	// ----
	sequence req_s;
		cyc_i && stb_i && !ack_o && !err_o && sel_i[0];
	endsequence
	sequence bad_s;
		req_s ##0 adr_i > 4'h6;
	endsequence
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	bus_answer_a: assert property (req_s |=> ack_o ^ err_o) else $error("no single answer");
	unmapped_err_a: assert property (bad_s |=> err_o) else $error("no error on bad address");
	tx_ready_off_a: assert property (!fifo_enabled_o |=> tx_space_request_n_o == $past(tx_avail_o))
		else $error("tx ready wrong with queues off");
	trig_off_a: assert property (!fifo_enabled_o |-> !rx_trigger_o) else $error("trigger while off");
	rx_ready_hold_a: assert property (rx_put_i && !fifo_enabled_o && !cyc_i |=> ##1 !rx_data_request_n_o)
		else $error("rx ready not low after put");
	rx_trig_pin_a: assert property ($rose(rx_trigger_o) |=> ##1 !rx_data_request_n_o)
		else $error("rx ready not low on trigger");
	reset_pins_a: assert property ($fell(rst_i) |-> tx_space_request_n_o && rx_data_request_n_o && !irq_o
		&& !fifo_enabled_o) else $error("bad reset state");
endmodule // ufc_top_props

bind ufc_top ufc_top_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .sel_i, .ack_o, .err_o, .rx_put_i,
	.tx_avail_o, .tx_space_request_n_o, .rx_data_request_n_o, .fifo_enabled_o, .rx_trigger_o, .irq_o);

// ### test/ufc_top_tb.sv
// Self-checking bench for the FIFO control block
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module ufc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [3:0] adr_i = 0, sel_i = 4'h1;
	logic [31:0] dat_i = 0;
	logic tout = 0;
	wire [31:0] dat_o;
	wire ack_o, err_o, take, put, txn, rxn, irq, tav, fen, rtrig;
	wire [7:0] rxd, txd;
	int fail_count = 0, total_checks = 0, cyc_cnt = 0;
	int thr[4] = '{1, 4, 8, 14};
	ufc_line_model lm (.clk_i, .tx_take_o(take), .rx_put_o(put), .rx_data_o(rxd));
	ufc_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
		.tx_take_i(take), .tx_data_o(txd), .tx_avail_o(tav), .rx_put_i(put), .rx_data_i(rxd),
		.rx_timeout_i(tout), .tx_space_request_n_o(txn), .rx_data_request_n_o(rxn),
		.fifo_enabled_o(fen), .rx_trigger_o(rtrig), .irq_o(irq));
	always #4 clk_i = ~clk_i;
	task results;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 5000)
		begin
			fail_count++;
			results;
		end
	end
	// Returns {err, read data}
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [32:0] q);
		int n;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		n = 0;
		do @(posedge clk_i); while (!(ack_o | err_o) && ++n < 50);
		if (n >= 50)
			fail_count++;
		q = {err_o, dat_o};
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask
	task settle;
		repeat (2) @(posedge clk_i);
	endtask
	task s_reset;
		logic [32:0] q;
		wb(0, 4'h0, 0, q); `CHK(q, 33'h0)
		`CHK(txn, 1'b0)
		`CHK(rxn, 1'b1)
		wb(0, 4'h7, 0, q); `CHK(q[32], 1'b1)
		wb(1, 4'h1, 8'h5a, q); settle; `CHK(txn, 1'b1)
		`CHK(txd, 8'h5a)
		`CHK(tav, 1'b1)
		lm.take; settle; `CHK(txn, 1'b0)
		lm.put(8'h3c); settle; `CHK(rxn, 1'b0)
		wb(0, 4'h2, 0, q); `CHK(q[7:0], 8'h3c)
		settle; `CHK(rxn, 1'b1)
	endtask
	task s_ctrl;
		logic [32:0] q;
		wb(1, 4'h0, 8'hc8, q); wb(0, 4'h0, 0, q); `CHK(q[7:0], 8'h00)
		wb(1, 4'h0, 8'hff, q); wb(0, 4'h0, 0, q); `CHK(q[7:0], 8'hc9)
	endtask
	task s_thr;
		logic [32:0] q;
		for (int c = 0; c < 4; c++)
		begin
			wb(1, 4'h0, {c[1:0], 6'h0b}, q);
			repeat (thr[c] - 1) lm.put(8'h11);
			settle; `CHK(rxn, 1'b1)
			lm.put(8'h22); settle; `CHK(rxn, 1'b0)
			`CHK(rtrig, 1'b1)
			repeat (17 - thr[c]) lm.put(8'h33);
			wb(0, 4'h3, 0, q); `CHK(q[12:8], 5'h10)
			`CHK(rxn, 1'b0)
			wb(1, 4'h0, 8'h0b, q); settle; `CHK(rxn, 1'b1)
		end
	endtask
	task s_tx;
		logic [32:0] q;
		wb(1, 4'h0, 8'h0d, q);
		repeat (15) wb(1, 4'h1, 8'h44, q);
		settle; `CHK(txn, 1'b0)
		repeat (2) wb(1, 4'h1, 8'h45, q);
		settle; `CHK(txn, 1'b1)
		lm.take; settle; `CHK(txn, 1'b0)
		wb(1, 4'h0, 8'h0d, q); wb(0, 4'h3, 0, q); `CHK(q[4:0], 5'h00)
	endtask
	task s_irq;
		logic [32:0] q;
		wb(1, 4'h0, 8'h03, q); wb(1, 4'h5, 8'h00, q); wb(1, 4'h6, 8'h07, q);
		lm.put(8'h55); settle; `CHK(irq, 1'b0)
		`CHK(rxn, 1'b0)
		wb(0, 4'h4, 0, q); `CHK(q[0], 1'b1)
		wb(1, 4'h5, 8'h01, q); settle; `CHK(irq, 1'b1)
		wb(1, 4'h6, 8'h01, q); settle; `CHK(irq, 1'b0)
	endtask
	task s_tout;
		logic [32:0] q;
		wb(1, 4'h0, 8'hcb, q); `CHK(fen, 1'b1)
		lm.put(8'h66); settle; `CHK(rxn, 1'b1)
		`CHK(rtrig, 1'b0)
		`CHK(tav, 1'b0)
		tout <= 1'b1;
		@(posedge clk_i);
		tout <= 1'b0;
		settle; `CHK(rxn, 1'b0)
		wb(0, 4'h4, 0, q); `CHK(q[1], 1'b1)
		wb(0, 4'h2, 0, q); `CHK(q[7:0], 8'h66)
		settle; `CHK(rxn, 1'b1)
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		s_reset;
		s_ctrl;
		s_thr;
		s_tx;
		s_irq;
		s_tout;
		results;
	end
endmodule // ufc_top_tb

// ### verilog/ufc_mem.v
// Character storage for one queue, registered read data
module ufc_mem #(
	parameter DW = 8,
	parameter AW = 4
) (
	// Clock
	input  wire          clk_i,
	// Write port
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [DW-1:0] wdata_i,
	// Read port
	input  wire [AW-1:0] raddr_i,
	output reg  [DW-1:0] rdata_o
);

	reg [DW-1:0] mem_r [0:(1<<AW)-1];

	always @(posedge clk_i)
	begin
		if (we_i)
			mem_r[waddr_i] <= wdata_i;
		rdata_o <= mem_r[raddr_i];
	end

endmodule // ufc_mem

// ### verilog/ufc_queue.v
// One character queue with flush, count and show-ahead registered head
module ufc_queue #(
	parameter DW = 8,
	parameter AW = 4
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          rst_i,
	// Control
	input  wire          flush_i,
	input  wire          single_i,
	// Push side
	input  wire          push_i,
	input  wire [DW-1:0] push_data_i,
	// Pop side
	input  wire          pop_i,
	output wire [DW-1:0] head_o,
	// Status
	output reg  [AW:0]   count_o,
	output wire          full_o,
	output wire          empty_o
);

	reg  [AW-1:0] wptr_r;
	reg  [AW-1:0] rptr_r;
	wire [AW:0]   cap;
	wire          do_push;
	wire          do_pop;
	wire [AW-1:0] rptr_nxt;

	// Single-byte holding mode caps the queue at one entry
	assign cap      = single_i ? {{AW{1'b0}}, 1'b1} : {1'b1, {AW{1'b0}}};
	assign full_o   = (count_o >= cap);
	assign empty_o  = (count_o == {(AW+1){1'b0}});
	assign do_push  = push_i & ~full_o;
	assign do_pop   = pop_i & ~empty_o;
	assign rptr_nxt = do_pop ? rptr_r + 1'b1 : rptr_r;

	always @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wptr_r  <= {AW{1'b0}};
			rptr_r  <= {AW{1'b0}};
			count_o <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wptr_r <= wptr_r + 1'b1;
			rptr_r <= rptr_nxt;
			count_o <= count_o + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		end
	end

	// Read address looks ahead so head_o is valid the cycle after a pop
	ufc_mem #(.DW(DW), .AW(AW)) u_mem (
		.clk_i   (clk_i),
		.we_i    (do_push),
		.waddr_i (wptr_r),
		.wdata_i (push_data_i),
		.raddr_i (rptr_nxt),
		.rdata_o (head_o)
	);

endmodule // ufc_queue

// ### verilog/ufc_top.v
// UART channel FIFO control, DMA ready pins and register slave
//
// Added by the designer: the register addresses and register access over Wishbone.
`include "ufc_map.vh"

module ufc_top #(
	parameter DW = 8,
	parameter AW = 4
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          rst_i,
	// Wishbone slave
	input  wire          cyc_i,
	input  wire          stb_i,
	input  wire          we_i,
	input  wire [3:0]    adr_i,
	input  wire [3:0]    sel_i,
	input  wire [31:0]   dat_i,
	output reg  [31:0]   dat_o,
	output wire          ack_o,
	output wire          err_o,
	// Transmit side toward the shift engine
	input  wire          tx_take_i,
	output wire [DW-1:0] tx_data_o,
	output wire          tx_avail_o,
	// Receive side from the shift engine
	input  wire          rx_put_i,
	input  wire [DW-1:0] rx_data_i,
	input  wire          rx_timeout_i,
	// DMA ready pins
	output reg           tx_space_request_n_o,
	output reg           rx_data_request_n_o,
	// Status toward the rest of the channel
	output wire          fifo_enabled_o,
	output wire          rx_trigger_o,
	output wire          irq_o
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	reg          ack_r;
	reg          mapped_r;
	wire         req;
	wire         wr;
	wire         rd;
	wire         mapped;

	assign req    = cyc_i & stb_i & ~ack_r;
	// Writes land on the edge after the one that shows ack, while the master still holds the request
	assign wr     = cyc_i & stb_i & ack_r & mapped_r & we_i & sel_i[0];
	assign rd     = req & ~we_i;
	assign mapped = (adr_i <= `UFC_ADR_IRQ_CLR);
	assign ack_o  = ack_r & mapped_r;
	assign err_o  = ack_r & ~mapped_r;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r    <= 1'b0;
			mapped_r <= 1'b0;
		end
		else
		begin
			ack_r    <= req;
			mapped_r <= mapped;
		end
	end

	// ----------------------------------------------------------------
	// fifo_control register
	// ----------------------------------------------------------------
	reg          fifo_en_r;
	reg          dma_mode_r;
	reg  [1:0]   rx_threshold_select_r;
	reg          tx_queue_flush_r;
	reg          rx_queue_flush_r;
	wire         ctl_wr;
	wire         was_en;

	assign ctl_wr = wr && (adr_i == `UFC_ADR_CTRL);
	assign was_en = dat_i[`UFC_CTL_EN];

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fifo_en_r             <= 1'b0;
			dma_mode_r            <= 1'b0;
			rx_threshold_select_r <= 2'h0;
			tx_queue_flush_r      <= 1'b0;
			rx_queue_flush_r      <= 1'b0;
		end
		else
		begin
			// Flush strobes last one cycle and always read back zero
			tx_queue_flush_r <= 1'b0;
			rx_queue_flush_r <= 1'b0;
			if (ctl_wr)
			begin
				fifo_en_r <= was_en;
				if (was_en)
				begin
					dma_mode_r            <= dat_i[`UFC_CTL_DMA];
					rx_threshold_select_r <= dat_i[`UFC_CTL_THR_HI:`UFC_CTL_THR_LO];
					tx_queue_flush_r      <= dat_i[`UFC_CTL_TXFL];
					rx_queue_flush_r      <= dat_i[`UFC_CTL_RXFL];
				end
				// Leaving FIFO mode empties both queues so stale bytes never leak
				else if (fifo_en_r)
				begin
					tx_queue_flush_r <= 1'b1;
					rx_queue_flush_r <= 1'b1;
				end
			end
		end
	end

	assign fifo_enabled_o = fifo_en_r;

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	wire [AW:0]  tx_count;
	wire [AW:0]  rx_count;
	wire         tx_full;
	wire         tx_empty;
	wire         rx_full;
	wire         rx_empty;
	wire [DW-1:0] rx_head;
	wire         tx_push;
	wire         rx_pop;

	assign tx_push = wr && (adr_i == `UFC_ADR_TXDATA);
	assign rx_pop  = rd && (adr_i == `UFC_ADR_RXDATA);

	ufc_queue #(.DW(DW), .AW(AW)) u_txq (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (tx_queue_flush_r),
		.single_i    (~fifo_en_r),
		.push_i      (tx_push),
		.push_data_i (dat_i[DW-1:0]),
		.pop_i       (tx_take_i),
		.head_o      (tx_data_o),
		.count_o     (tx_count),
		.full_o      (tx_full),
		.empty_o     (tx_empty)
	);

	ufc_queue #(.DW(DW), .AW(AW)) u_rxq (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (rx_queue_flush_r),
		.single_i    (~fifo_en_r),
		.push_i      (rx_put_i),
		.push_data_i (rx_data_i),
		.pop_i       (rx_pop),
		.head_o      (rx_head),
		.count_o     (rx_count),
		.full_o      (rx_full),
		.empty_o     (rx_empty)
	);

	assign tx_avail_o = ~tx_empty;

	// ----------------------------------------------------------------
	// Threshold and DMA ready pins
	// ----------------------------------------------------------------
	reg  [AW:0]  rx_thr;
	reg          rx_latched_r;
	reg          trig_prev_r;
	wire         rx_trig;

	always @*
	begin
		case (rx_threshold_select_r)
			2'h0:    rx_thr = `UFC_THR_0;
			2'h1:    rx_thr = `UFC_THR_1;
			2'h2:    rx_thr = `UFC_THR_2;
			default: rx_thr = `UFC_THR_3;
		endcase
	end

	// Level while the receive count is at or above the selected threshold, FIFO mode on
	assign rx_trig      = fifo_en_r && (rx_count >= rx_thr);
	assign rx_trigger_o = rx_trig;

	always @(posedge clk_i)
	begin
		if (rst_i || rx_queue_flush_r)
			rx_latched_r <= 1'b0;
		else if (rx_empty)
			rx_latched_r <= 1'b0;
		else if (rx_trig || rx_timeout_i)
			rx_latched_r <= 1'b1;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_space_request_n_o <= 1'b1;
			rx_data_request_n_o  <= 1'b1;
		end
		else if (fifo_en_r && dma_mode_r)
		begin
			tx_space_request_n_o <= tx_full;
			rx_data_request_n_o  <= ~(rx_latched_r & ~rx_empty);
		end
		else
		begin
			tx_space_request_n_o <= ~tx_empty;
			rx_data_request_n_o  <= rx_empty;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------------------------------
	reg  [`UFC_IRQ_W-1:0] irq_stat_r;
	reg  [`UFC_IRQ_W-1:0] irq_en_r;
	wire [`UFC_IRQ_W-1:0] irq_set;
	wire [`UFC_IRQ_W-1:0] irq_clr;

	always @(posedge clk_i)
	begin
		if (rst_i)
			trig_prev_r <= 1'b0;
		else
			trig_prev_r <= rx_trig;
	end

	assign irq_set[`UFC_IRQ_TRIG]  = rx_trig & ~trig_prev_r;
	assign irq_set[`UFC_IRQ_TOUT]  = rx_timeout_i & fifo_en_r;
	assign irq_set[`UFC_IRQ_RXOVR] = rx_put_i & rx_full;
	assign irq_clr = (wr && (adr_i == `UFC_ADR_IRQ_CLR)) ? dat_i[`UFC_IRQ_W-1:0] : {`UFC_IRQ_W{1'b0}};

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat_r <= {`UFC_IRQ_W{1'b0}};
			irq_en_r   <= {`UFC_IRQ_W{1'b0}};
		end
		else
		begin
			// Set beats clear in the same cycle
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			if (wr && (adr_i == `UFC_ADR_IRQ_EN))
				irq_en_r <= dat_i[`UFC_IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_stat_r & irq_en_r);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h00000000;
		else if (rd)
		begin
			dat_o <= 32'h00000000;
			case (adr_i)
				// Flush bits and bits five, four always read zero
				`UFC_ADR_CTRL:     dat_o[7:0] <= {rx_threshold_select_r, 2'h0, dma_mode_r, 2'h0, fifo_en_r};
				`UFC_ADR_RXDATA:   dat_o[DW-1:0] <= rx_head;
				`UFC_ADR_LEVELS:   dat_o[15:0] <= {{(8-AW-1){1'b0}}, rx_count, {(8-AW-1){1'b0}}, tx_count};
				`UFC_ADR_IRQ_STAT: dat_o[`UFC_IRQ_W-1:0] <= irq_stat_r;
				`UFC_ADR_IRQ_EN:   dat_o[`UFC_IRQ_W-1:0] <= irq_en_r;
				default:           dat_o <= 32'h00000000;
			endcase
		end
	end

endmodule // ufc_top
